// ### hw/itc_consts.svh
`ifndef ITC_CONSTS_SVH
`define ITC_CONSTS_SVH

// ==========================================================
// Dataway function codes
`define ITC_F_READ 5'h00
`define ITC_F_TEST_LAM 5'h08
`define ITC_F_CLR_TIME 5'h09
`define ITC_F_CLR_LAM 5'h0a
`define ITC_F_WRITE 5'h10
`define ITC_F_STOP 5'h18

// ==========================================================
// Dataway sub-addresses
`define ITC_A_TIME_LO 4'h0
`define ITC_A_TIME_HI 4'h1
`define ITC_A_INTERVAL 4'h2

// ==========================================================
// Interval preset limits and rate selector codes
`define ITC_PRESET_MIN 24'h000001
`define ITC_PRESET_MAX 24'h000063
`define ITC_RATE_1S 2'h0
`define ITC_RATE_10S 2'h1
`define ITC_RATE_1M 2'h2
`define ITC_RATE_1H 2'h3

// ==========================================================
// Time base: mains cycles per tenth of a second
`define ITC_LINE50_PER_TENTH 3'h5
`define ITC_LINE60_PER_TENTH 3'h6

// ==========================================================
// Counter stage moduli
`define ITC_MOD_TENTH 10
`define ITC_MOD_SEC 60
`define ITC_MOD_MIN 60
`define ITC_MOD_HOUR 24
`define ITC_MOD_DAY 1000

`endif

// ### hw/itc_pkg.sv
package itc_pkg;

    // ==========================================================
    // Register state of the clock module; the time-of-day digit stages keep their own
    typedef struct packed {
        logic [2:0] line_sy;   // Mains pulse synchroniser
        logic [2:0] ext_sy;    // External pulse synchroniser
        logic [2:0] n_sy;      // Station select synchroniser
        logic [2:0] s1_sy;     // Strobe synchroniser
        logic line_lv;
        logic ext_lv;
        logic n_lv;
        logic s1_lv;
        logic [2:0] line_cnt;  // Mains cycles within the tenth
        logic run;             // Interval count in progress
        logic [6:0] ivl;       // Interval remaining
        logic lam;             // Look-at-me request
        logic [23:0] rd;       // Read data on the Dataway
        logic q;
        logic x;
    } itc_state_t;

endpackage

// ### hw/itc_digit.sv
`timescale 1ns/1ps

module itc_digit #(
    parameter int MODULUS = 10,
    parameter int WIDTH = 4
) (
    input wire logic clk,               // System clock
    input wire logic reset_n,           // Asynchronous reset
    input wire logic clr,               // Synchronous clear
    input wire logic inc,               // Advance by one
    output logic [WIDTH-1:0] value,     // Current count
    output logic carry                  // Wrap pulse into next stage
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } itc_digit_state_t;

    itc_digit_state_t state_ff;
    itc_digit_state_t nxt_state;

    localparam logic [WIDTH-1:0] LAST = WIDTH'(MODULUS - 1);

    // ==========================================================
    // Wrap at the modulus, carry is combinational
    assign carry = inc && (state_ff.cnt == LAST); // [R01]
    assign value = state_ff.cnt;

    always_comb begin
        nxt_state = state_ff;
        if (clr) begin
            nxt_state.cnt = '0;
        end else if (carry) begin
            nxt_state.cnt = '0;
        end else if (inc) begin
            nxt_state.cnt = state_ff.cnt + WIDTH'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_digit_wrap: assert property (carry && !clr |=> value == '0) // [R01]
        else $error("stage did not wrap after carry");
    a_digit_range: assert property (value <= LAST) // [R01]
        else $error("stage count beyond modulus");
endmodule

// ### hw/itc_clock.sv
`timescale 1ns/1ps
`include "itc_consts.svh"

// Notes on behaviour
// [R01] Time counts tenths through seconds, minutes, hours, days
// [R02] Time base from mains or external pulses
// [R03] Mains timing correct at 50 or 60 Hz
// [R04] Interval counter preset from 1 to 99
// [R05] Interval decrements at panel-selected main counter tap
// [R06] Preset and rate span one second to 99 hours
// [R07] Interval end raises look-at-me request
// [R08] Gate enable output active during interval count
// [R09] Panel indicator lit while interval counting
// [R10] Look-at-me held until controller clears it
// [R11] Commands act only during addressed Dataway cycle
module itc_clock import itc_pkg::*; (
    input wire logic clk,               // 100 MHz system clock
    input wire logic reset_n,           // Asynchronous reset, active low
    input wire logic line_in,           // Mains frequency square wave
    input wire logic ext_pulse,         // External time base pulse
    input wire logic src_ext,           // Panel: 1 selects external pulses
    input wire logic freq_60,           // Panel: 1 for 60 Hz mains
    input wire logic [1:0] rate_sel,    // Panel: interval rate switch
    input wire logic dw_n,              // Station addressed
    input wire logic dw_s1,             // Dataway strobe S1
    input wire logic [4:0] dw_f,        // Function code
    input wire logic [3:0] dw_a,        // Sub-address
    input wire logic [23:0] dw_w,       // Write lines
    output logic [23:0] dw_r,           // Read lines
    output logic dw_q,                  // Q response
    output logic dw_x,                  // Command accepted
    output logic dw_l,                  // Look-at-me request
    output logic gate_en,               // Panel gate for scalers
    output logic led_on                 // Panel progress indicator
);
    itc_state_t state_ff;
    itc_state_t nxt_state;

    logic base_tick;
    logic line_rise;
    logic ext_rise;
    logic s1_rise;
    logic cmd;
    logic rate_tick;
    logic clr_time;
    logic [2:0] line_per;
    logic [3:0] tenth_v;
    logic [5:0] sec_v;
    logic [5:0] min_v;
    logic [4:0] hour_v;
    logic [9:0] day_v;
    logic tenth_c;
    logic sec_c;
    logic min_c;
    logic hour_c;
    logic ten_s_tick;
    logic preset_ok;

    // ==========================================================
    // Edge detection on filtered levels
    // Taken from registered state only, so no edge loops back through nxt_state
    assign line_rise = state_ff.line_sy[1] && state_ff.line_sy[2] && !state_ff.line_lv;
    assign ext_rise = state_ff.ext_sy[1] && state_ff.ext_sy[2] && !state_ff.ext_lv;
    assign s1_rise = state_ff.s1_sy[1] && state_ff.s1_sy[2] && !state_ff.s1_lv;
    // Only a strobe inside an addressed cycle is a command
    assign cmd = s1_rise && state_ff.n_lv; // [R11]

    // Tenth-second tick from the chosen source
    assign line_per = freq_60 ? `ITC_LINE60_PER_TENTH : `ITC_LINE50_PER_TENTH; // [R03]
    assign base_tick = src_ext ? ext_rise
                               : (line_rise && state_ff.line_cnt == line_per - 3'h1); // [R02]

    assign clr_time = cmd && dw_f == `ITC_F_CLR_TIME && dw_a == `ITC_A_TIME_LO;

    // ==========================================================
    // Time-of-day chain
    itc_digit #(.MODULUS(`ITC_MOD_TENTH), .WIDTH(4)) u_tenth (
        .clk(clk), .reset_n(reset_n), .clr(clr_time), .inc(base_tick),
        .value(tenth_v), .carry(tenth_c)
    );
    itc_digit #(.MODULUS(`ITC_MOD_SEC), .WIDTH(6)) u_sec (
        .clk(clk), .reset_n(reset_n), .clr(clr_time), .inc(tenth_c),
        .value(sec_v), .carry(sec_c)
    );
    itc_digit #(.MODULUS(`ITC_MOD_MIN), .WIDTH(6)) u_min (
        .clk(clk), .reset_n(reset_n), .clr(clr_time), .inc(sec_c),
        .value(min_v), .carry(min_c)
    );
    itc_digit #(.MODULUS(`ITC_MOD_HOUR), .WIDTH(5)) u_hour (
        .clk(clk), .reset_n(reset_n), .clr(clr_time), .inc(min_c),
        .value(hour_v), .carry(hour_c)
    );
    itc_digit #(.MODULUS(`ITC_MOD_DAY), .WIDTH(10)) u_day (
        .clk(clk), .reset_n(reset_n), .clr(clr_time), .inc(hour_c),
        .value(day_v), .carry()
    );

    // ==========================================================
    // Interval rate tap; 1 s x 1 up to 1 h x 99 covers the span
    assign ten_s_tick = sec_c || (tenth_c && (sec_v % 6'd10) == 6'd9);
    always_comb begin
        case (rate_sel) // [R05] [R06]
            `ITC_RATE_1S: rate_tick = tenth_c;
            `ITC_RATE_10S: rate_tick = ten_s_tick;
            `ITC_RATE_1M: rate_tick = sec_c;
            default: rate_tick = min_c;
        endcase
    end

    assign preset_ok = dw_w >= `ITC_PRESET_MIN && dw_w <= `ITC_PRESET_MAX; // [R04]

    // ==========================================================
    // Next-state logic
    always_comb begin
        nxt_state = state_ff;
        // Three-stage synchronisers, level taken when stages 2 and 3 agree
        nxt_state.line_sy = {state_ff.line_sy[1:0], line_in};
        nxt_state.ext_sy = {state_ff.ext_sy[1:0], ext_pulse};
        nxt_state.n_sy = {state_ff.n_sy[1:0], dw_n};
        nxt_state.s1_sy = {state_ff.s1_sy[1:0], dw_s1};
        if (state_ff.line_sy[1] == state_ff.line_sy[2]) begin
            nxt_state.line_lv = state_ff.line_sy[2];
        end
        if (state_ff.ext_sy[1] == state_ff.ext_sy[2]) begin
            nxt_state.ext_lv = state_ff.ext_sy[2];
        end
        if (state_ff.n_sy[1] == state_ff.n_sy[2]) begin
            nxt_state.n_lv = state_ff.n_sy[2];
        end
        if (state_ff.s1_sy[1] == state_ff.s1_sy[2]) begin
            nxt_state.s1_lv = state_ff.s1_sy[2];
        end

        // Mains cycle divider; restarts in external mode
        if (src_ext) begin
            nxt_state.line_cnt = 3'h0;
        end else if (line_rise) begin
            if (state_ff.line_cnt >= line_per - 3'h1) begin // [R03]
                nxt_state.line_cnt = 3'h0;
            end else begin
                nxt_state.line_cnt = state_ff.line_cnt + 3'h1;
            end
        end

        // Interval count-down; end of period raises the request
        if (state_ff.run && rate_tick) begin
            if (state_ff.ivl <= 7'h01) begin
                nxt_state.ivl = 7'h00;
                nxt_state.run = 1'b0; // [R08] [R09]
            end else begin
                nxt_state.ivl = state_ff.ivl - 7'h01; // [R05]
            end
        end

        // Responses fall away when the station is released
        if (!state_ff.n_lv) begin
            nxt_state.rd = 24'h000000;
            nxt_state.q = 1'b0;
            nxt_state.x = 1'b0;
        end

        // Dataway commands, acted on once per strobe
        if (cmd) begin // [R11]
            nxt_state.x = 1'b1;
            nxt_state.q = 1'b1;
            nxt_state.rd = 24'h000000;
            if (dw_f == `ITC_F_READ && dw_a == `ITC_A_TIME_LO) begin
                nxt_state.rd = {8'h00, min_v, sec_v, tenth_v};
            end else if (dw_f == `ITC_F_READ && dw_a == `ITC_A_TIME_HI) begin
                nxt_state.rd = {9'h000, day_v, hour_v};
            end else if (dw_f == `ITC_F_READ && dw_a == `ITC_A_INTERVAL) begin
                nxt_state.rd = {16'h0000, state_ff.run, state_ff.ivl};
            end else if (dw_f == `ITC_F_TEST_LAM) begin
                nxt_state.q = state_ff.lam;
            end else if (clr_time || dw_f == `ITC_F_CLR_LAM) begin
                nxt_state.q = 1'b1;
            end else if (dw_f == `ITC_F_WRITE && dw_a == `ITC_A_INTERVAL) begin
                // Out-of-range preset is refused with Q low
                nxt_state.q = preset_ok;
                if (preset_ok) begin
                    nxt_state.ivl = dw_w[6:0]; // [R04]
                    nxt_state.run = 1'b1;
                end
            end else if (dw_f == `ITC_F_STOP) begin
                nxt_state.run = 1'b0;
            end else begin
                nxt_state.x = 1'b0;
                nxt_state.q = 1'b0;
            end
        end

        // Sticky request; an interval end in the clearing cycle still wins
        if (cmd && dw_f == `ITC_F_CLR_LAM) begin
            nxt_state.lam = 1'b0; // [R10]
        end
        if (state_ff.run && rate_tick && state_ff.ivl <= 7'h01) begin
            nxt_state.lam = 1'b1; // [R07]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign dw_r = state_ff.rd;
    assign dw_q = state_ff.q;
    assign dw_x = state_ff.x;
    assign dw_l = state_ff.lam; // [R07]
    assign gate_en = state_ff.run; // [R08]
    assign led_on = state_ff.run; // [R09]

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_last_tick;
        state_ff.run && rate_tick && state_ff.ivl == 7'h01;
    endsequence
    sequence s_ended;
        dw_l && !gate_en && !led_on;
    endsequence

    a_lam_on_end: assert property (s_last_tick |=> s_ended) // [R07]
        else $error("interval end did not raise request");
    a_lam_held: assert property (dw_l && !(cmd && dw_f == `ITC_F_CLR_LAM) |=> dw_l) // [R10]
        else $error("request dropped without clear command");
    a_gate_falls: assert property ($rose(dw_l) |-> $fell(gate_en) || !gate_en) // [R08]
        else $error("gate still open after interval end");
    a_led_gate: assert property (led_on == gate_en && (!led_on || state_ff.ivl != 7'h00)) // [R09]
        else $error("indicator lit with no count left");
    a_preset_range: assert property (state_ff.ivl <= 7'd99) // [R04]
        else $error("interval count above 99");
    a_preset_load: assert property (cmd && dw_f == `ITC_F_WRITE // [R04]
        && dw_a == `ITC_A_INTERVAL && preset_ok
        |=> state_ff.ivl == $past(dw_w[6:0]) && gate_en ##1 dw_x)
        else $error("preset not loaded");
    a_decrement: assert property (state_ff.run && rate_tick && state_ff.ivl > 7'h01 // [R05]
        && !cmd |=> state_ff.ivl == $past(state_ff.ivl) - 7'h01)
        else $error("interval did not step down");
    a_tenth_roll: assert property (base_tick && tenth_v == 4'h9 && !clr_time // [R01]
        |=> tenth_v == 4'h0 && sec_v != $past(sec_v))
        else $error("tenths did not carry into seconds");
    a_mains_div: assert property (!src_ext |-> state_ff.line_cnt < line_per) // [R03]
        else $error("mains divider out of range");
    a_ext_source: assert property (src_ext && base_tick |-> ext_rise) // [R02]
        else $error("tick without external pulse");
    a_unaddressed: assert property (!state_ff.n_lv |=> !dw_x && !dw_q) // [R11]
        else $error("response without address");
endmodule

// ### tb/itc_ctrl_model.sv
`timescale 1ns/1ps

// ==========================================================
// Crate controller: one Dataway cycle per call
module itc_ctrl_model (
    input wire logic clk,           // System clock
    output logic dw_n,              // Station addressed
    output logic dw_s1,             // Strobe
    output logic [4:0] dw_f,        // Function code
    output logic [3:0] dw_a,        // Sub-address
    output logic [23:0] dw_w,       // Write lines
    input wire logic [23:0] dw_r,   // Read lines
    input wire logic dw_q,          // Q response
    input wire logic dw_x           // Command accepted
);
    // Idle lines show a pattern, never a stale command
    initial begin
        dw_n = 1'b0;
        dw_s1 = 1'b0;
        dw_f = 5'h1f;
        dw_a = 4'hf;
        dw_w = 24'hffffff;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Lines held until the answer is taken, then released
    task automatic cmd(input logic sel, input logic [4:0] f, input logic [3:0] a,
                       input logic [23:0] w, output logic [23:0] r,
                       output logic q, output logic x);
        step(1);
        dw_n = sel;
        dw_f = f;
        dw_a = a;
        dw_w = w;
        step(5);
        dw_s1 = 1'b1;
        step(10);
        r = dw_r;
        q = dw_q;
        x = dw_x;
        dw_s1 = 1'b0;
        step(3);
        // Inverse values so a late sample cannot look right
        dw_n = 1'b0;
        dw_f = ~f;
        dw_a = ~a;
        dw_w = ~w;
        step(8);
    endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "itc_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module testbench;
    logic clk = 1'b0;
    logic reset_n, line_in, ext_pulse, src_ext, freq_60;
    logic [1:0] rate_sel;
    logic dw_n, dw_s1, dw_q, dw_x, dw_l, gate_en, led_on;
    logic [4:0] dw_f;
    logic [3:0] dw_a;
    logic [23:0] dw_w, dw_r, r;
    logic q, x;
    logic [31:0] seed = 32'h9ba53020;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int tt = 0;

    always #5 clk = ~clk;

    itc_clock dut (.clk(clk), .reset_n(reset_n), .line_in(line_in), .ext_pulse(ext_pulse),
        .src_ext(src_ext), .freq_60(freq_60), .rate_sel(rate_sel), .dw_n(dw_n),
        .dw_s1(dw_s1), .dw_f(dw_f), .dw_a(dw_a), .dw_w(dw_w), .dw_r(dw_r), .dw_q(dw_q),
        .dw_x(dw_x), .dw_l(dw_l), .gate_en(gate_en), .led_on(led_on));

    itc_ctrl_model ctrl (.clk(clk), .dw_n(dw_n), .dw_s1(dw_s1), .dw_f(dw_f), .dw_a(dw_a),
        .dw_w(dw_w), .dw_r(dw_r), .dw_q(dw_q), .dw_x(dw_x));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic close_out;
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard; the whole run needs roughly 11.4k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            close_out;
        end
    end

    // ==========================================================
    // Stimulus helpers
    // Rising edges on the selected time base; only ext mode is one tenth each
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            if (src_ext) ext_pulse = 1'b1; else line_in = 1'b1;
            step(4);
            ext_pulse = 1'b0;
            line_in = 1'b0;
            step(4);
            if (src_ext) tt++;
        end
    endtask

    task automatic do_cmd(input logic [4:0] f, input logic [3:0] a, input logic [23:0] w);
        ctrl.cmd(1'b1, f, a, w, r, q, x);
    endtask

    task automatic chk_time;
        do_cmd(`ITC_F_READ, `ITC_A_TIME_LO, 24'h0);
        `CHK(r, {8'h0, 6'(tt / 600 % 60), 6'(tt / 10 % 60), 4'(tt % 10)})
        do_cmd(`ITC_F_READ, `ITC_A_TIME_HI, 24'h0);
        `CHK(r, {9'h0, 10'(tt / 864000), 5'(tt / 36000 % 24)})
    endtask

    // Interval of p taps; the tap falls where the model's tenths cross a period
    task automatic run_ivl(input logic [1:0] rate, input int p);
        int per;
        int n;
        per = (rate == 2'h0) ? 10 : (rate == 2'h1) ? 100 : 600;
        rate_sel = rate;
        do_cmd(`ITC_F_WRITE, `ITC_A_INTERVAL, 24'(p));
        `CHK({x, q, gate_en, led_on}, 4'hf)
        n = per - tt % per + per * (p - 1);
        pulses(n - 1);
        `CHK({gate_en, led_on, dw_l}, 3'b110)
        pulses(1);
        `CHK({gate_en, led_on, dw_l}, 3'b001)
        do_cmd(`ITC_F_TEST_LAM, 4'h0, 24'h0);
        `CHK({q, dw_l}, 2'b11)
        do_cmd(`ITC_F_CLR_LAM, 4'h0, 24'h0);
        `CHK({q, dw_l}, 2'b10)
        do_cmd(`ITC_F_TEST_LAM, 4'h0, 24'h0);
        `CHK(q, 1'b0)
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        reset_n = 1'b0;
        line_in = 1'b0;
        ext_pulse = 1'b0;
        src_ext = 1'b1;
        freq_60 = 1'b0;
        rate_sel = 2'h0;
        repeat (12) @(posedge clk);
        #1;
        reset_n = 1'b1;
        `CHK({dw_r, dw_q, dw_x, dw_l, gate_en, led_on}, 29'h0)
        step(2);
        chk_time;
        pulses(625);
        chk_time;
        // Strobe without station address must do nothing
        ctrl.cmd(1'b0, `ITC_F_WRITE, `ITC_A_INTERVAL, 24'h5, r, q, x);
        `CHK({x, q, gate_en}, 3'b000)
        do_cmd(5'h01, 4'h0, 24'h0);
        `CHK({x, q}, 2'b00)
        // Presets just outside 1..99 are taken but refused
        do_cmd(`ITC_F_WRITE, `ITC_A_INTERVAL, 24'h0);
        `CHK({x, q, gate_en}, 3'b100)
        do_cmd(`ITC_F_WRITE, `ITC_A_INTERVAL, 24'h64);
        `CHK({x, q, gate_en}, 3'b100)
        seed = lfsr(seed);
        run_ivl(2'h0, int'(seed % 32'h3) + 1);
        run_ivl(2'h1, 1);
        run_ivl(2'h2, 1);
        // Longest interval only loaded; an hour tap is far beyond the run
        rate_sel = 2'h3;
        do_cmd(`ITC_F_WRITE, `ITC_A_INTERVAL, 24'h63);
        do_cmd(`ITC_F_READ, `ITC_A_INTERVAL, 24'h0);
        `CHK(r, 24'h0000e3)
        do_cmd(`ITC_F_STOP, 4'h0, 24'h0);
        `CHK({q, gate_en, led_on, dw_l}, 4'h8)
        // Mains time base at both line frequencies
        for (int i = 0; i < 2; i++) begin
            do_cmd(`ITC_F_CLR_TIME, `ITC_A_TIME_LO, 24'h0);
            `CHK(q, 1'b1)
            src_ext = 1'b0;
            freq_60 = i[0];
            pulses(60);
            src_ext = 1'b1;
            tt = (i == 0) ? 12 : 10;
            chk_time;
        end
        close_out;
    end
endmodule
